// ===== spsc_fan_chan.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_fan_chan
#(
  parameter int DUTY_W = spsc_pkg::DUTY_W,
  parameter int TACH_W = spsc_pkg::TACH_W
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Timing enables
  input wire logic pwm_tick,
  input wire logic win_tick,
  // Control
  input wire logic fan_en,
  input wire logic closed_loop,
  input wire logic [DUTY_W-1:0] duty_set,
  input wire logic [TACH_W-1:0] tach_target,
  // Fan pins and monitoring
  input wire logic tach_pin,
  output logic pwm_out_ff,
  output logic [TACH_W-1:0] tach_cnt_ff
);

  // ----------------------------------------
  // Tach synchroniser and edge counter
  // ----------------------------------------
  logic [2:0] tach_sync_ff;
  logic [TACH_W-1:0] edge_cnt_ff;
  logic tach_rise;
  assign tach_rise = tach_sync_ff[1] & ~tach_sync_ff[2];

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      tach_sync_ff <= 3'h0;
    else
      tach_sync_ff <= {tach_sync_ff[1:0], tach_pin};

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      edge_cnt_ff <= '0;
      tach_cnt_ff <= '0;
    end
    else if (win_tick)
    begin
      tach_cnt_ff <= edge_cnt_ff;
      // An edge in the tick cycle opens the next window instead of being lost
      edge_cnt_ff <= {{(TACH_W-1){1'b0}}, tach_rise};
    end
    else if (tach_rise && edge_cnt_ff != '1)
      edge_cnt_ff <= edge_cnt_ff + 1'b1;

  // ----------------------------------------
  // Duty control
  // ----------------------------------------
  // One step per window keeps the loop slow and stable; tuning is left to software
  logic [DUTY_W-1:0] duty_ff;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      duty_ff <= '0;
    else if (!closed_loop)
      duty_ff <= duty_set;
    else if (win_tick)
    begin
      if (edge_cnt_ff < tach_target && duty_ff != '1)
        duty_ff <= duty_ff + 1'b1;
      else if (edge_cnt_ff > tach_target && duty_ff != '0)
        duty_ff <= duty_ff - 1'b1;
    end

  // ----------------------------------------
  // PWM generator
  // ----------------------------------------
  logic [DUTY_W-1:0] pwm_cnt_ff;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      pwm_cnt_ff <= '0;
    else if (pwm_tick)
      pwm_cnt_ff <= pwm_cnt_ff + 1'b1;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      pwm_out_ff <= 1'b0;
    else
      pwm_out_ff <= fan_en && (pwm_cnt_ff < duty_ff);

endmodule
`default_nettype wire

// ===== spsc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Front-panel switch and supply model
// ----------------------------------------
module spsc_panel_model
(
  // Clock
  input wire logic ref_clk,
  // Supply controls from the controller
  input wire logic psu_on_n,
  input wire logic stby_on,
  // Switch pin and rail levels
  output var logic pwr_sw_n,
  output logic rail_main,
  output logic rail_stby
);
  // Switch has a pull-up, so it idles released
  initial pwr_sw_n = 1'h1;
  // Main rails drop whenever the enable is high; standby follows its keep-alive
  assign rail_main = !psu_on_n;
  assign rail_stby = stby_on;
  // Change the pin just after a falling edge, away from the sampling edge
  task automatic sw_set(input logic down);
    @(negedge ref_clk);
    pwr_sw_n = !down;
  endtask
endmodule
`default_nettype wire

// ===== spsc_pkg.sv
// Function
// - A press shorter than four seconds moves soft-off to working, working to sleep, sleep to working.
// - A hold longer than six seconds forces soft-off from working or sleeping.
// - Switch, RTC, LAN, PME, WAKE and IR wake the system from S3, S4 or S5; USB wakes it from S3 only.
// - Wake from S4 needs the OS-support setting, and IR wake from S4 or S5 is a setting of its own.
// - S3 keeps context in RAM, S4 on disk, S5 none, so leaving S5 is flagged as a cold boot.
// - Apart from the switch and the wake paths, state changes only on an operating-system request.
// - A soft-off request drops every main rail while the standby rail stays on.
// - When AC power returns, the state that held before the outage can be restored.
// - The behaviour after AC return is chosen by a stored restore-policy setting.
// - Fans are enabled in S0.
// - Fans are disabled when the system is off or in S3, S4 or S5.
// - Each fan channel measures its tachometer and supports closed-loop speed or on/off control.
// - Four-wire fans get a pulse-width-modulated speed output.
// - An asserted express-bus WAKE signal wakes the system from S3, S4 or S5.
// - An asserted PME signal wakes the system from S3, S4 or S5 only while PME wake is enabled.
package spsc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SHORT_PRESS_S = 4;
  localparam int unsigned FORCE_OFF_S = 6;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned TACH_WIN_MS = 1000;
  localparam int unsigned FAN_PWM_HZ = 25_000;
  localparam int unsigned PWM_STEPS = 256;
  localparam int unsigned SHORT_PRESS_CYC = CLK_HZ * SHORT_PRESS_S;
  localparam int unsigned FORCE_OFF_CYC = CLK_HZ * FORCE_OFF_S;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned TACH_WIN_CYC = (CLK_HZ / 1000) * TACH_WIN_MS;
  localparam int unsigned PWM_DIV_CYC = CLK_HZ / (FAN_PWM_HZ * PWM_STEPS);

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int CNT_W = 28;
  localparam int DUTY_W = 8;
  localparam int TACH_W = 16;
  localparam int FAN_N = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_S0 = 2'h0,
    ST_S3 = 2'h1,
    ST_S4 = 2'h2,
    ST_S5 = 2'h3
  } spsc_state_t;

  typedef enum logic [1:0] {
    RP_STAY_OFF = 2'h0,
    RP_POWER_ON = 2'h1,
    RP_LAST = 2'h2
  } spsc_restore_t;

  typedef struct packed {
    logic rtc;
    logic lan;
    logic usb;
    logic pme;
    logic pcie;
    logic cir;
  } spsc_wake_t;

  typedef struct packed {
    logic pme_en;
    logic s4_os_ok;
    logic cir_deep_en;
    spsc_restore_t restore;
  } spsc_cfg_t;

endpackage

// ===== spsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_top
#(
  parameter int unsigned DEBOUNCE_CYC = spsc_pkg::DEBOUNCE_CYC,
  parameter int unsigned SHORT_PRESS_CYC = spsc_pkg::SHORT_PRESS_CYC,
  parameter int unsigned FORCE_OFF_CYC = spsc_pkg::FORCE_OFF_CYC,
  parameter int unsigned TACH_WIN_CYC = spsc_pkg::TACH_WIN_CYC,
  parameter int FAN_N = spsc_pkg::FAN_N
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Switch and wake pins
  input wire logic pwr_sw_n,
  input wire logic rtc_alarm,
  input wire logic lan_wake,
  input wire logic usb_wake,
  input wire logic pme_n,
  input wire logic pcie_wake_n,
  input wire logic cir_wake,
  // Operating-system requests
  input wire logic os_req,
  input wire spsc_pkg::spsc_state_t os_target,
  // Stored configuration
  input wire spsc_pkg::spsc_cfg_t cfg,
  input wire logic saved_last_on,
  // Power supply and status
  output logic psu_on_n_ff,
  output logic stby_on_ff,
  output spsc_pkg::spsc_state_t state_ff,
  output logic ctx_ram_ff,
  output logic cold_boot_ff,
  output logic last_on_ff,
  output logic press_over4_ff,
  // Fans
  input wire logic [FAN_N-1:0] fan_tach,
  input wire logic [FAN_N-1:0] fan_closed_loop,
  input wire logic [FAN_N-1:0][spsc_pkg::DUTY_W-1:0] fan_duty,
  input wire logic [FAN_N-1:0][spsc_pkg::TACH_W-1:0] fan_target,
  output logic fan_en_ff,
  output logic [FAN_N-1:0] fan_pwm,
  output logic [FAN_N-1:0][spsc_pkg::TACH_W-1:0] fan_speed
);

  localparam int CW = spsc_pkg::CNT_W;
  localparam int PIN_N = 7;

  // ----------------------------------------
  // Wake qualification
  // ----------------------------------------
  function automatic logic wake_ok(input spsc_pkg::spsc_state_t st,
                                   input spsc_pkg::spsc_wake_t w,
                                   input spsc_pkg::spsc_cfg_t c);
    logic deep;
    deep = w.rtc | w.lan | w.pcie | (w.pme & c.pme_en) | (w.cir & c.cir_deep_en);
    case (st)
      spsc_pkg::ST_S3: wake_ok = deep | w.usb | w.cir;
      spsc_pkg::ST_S4: wake_ok = deep & c.s4_os_ok;
      spsc_pkg::ST_S5: wake_ok = deep;
      default: wake_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync_a_ff;
  logic [PIN_N-1:0] sync_b_ff;
  spsc_pkg::spsc_wake_t wake;
  logic sw_raw;

  assign pin_raw = {~pwr_sw_n, rtc_alarm, lan_wake, usb_wake, ~pme_n, ~pcie_wake_n, cir_wake};
  assign wake = sync_b_ff[PIN_N-2:0];
  assign sw_raw = sync_b_ff[PIN_N-1];

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      sync_a_ff <= '0;
      sync_b_ff <= '0;
    end
    else
    begin
      sync_a_ff <= pin_raw;
      sync_b_ff <= sync_a_ff;
    end

  // ----------------------------------------
  // Switch debounce
  // ----------------------------------------
  logic [CW-1:0] db_cnt_ff;
  logic sw_ff;
  logic sw_prev_ff;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      db_cnt_ff <= '0;
      sw_ff <= 1'b0;
    end
    else if (sw_raw == sw_ff)
      db_cnt_ff <= '0;
    else if (db_cnt_ff == CW'(DEBOUNCE_CYC - 1))
    begin
      sw_ff <= sw_raw;
      db_cnt_ff <= '0;
    end
    else
      db_cnt_ff <= db_cnt_ff + 1'b1;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      sw_prev_ff <= 1'b0;
    else
      sw_prev_ff <= sw_ff;

  // ----------------------------------------
  // Press timer
  // ----------------------------------------
  // A hold that has already forced soft-off must not also count as a short press on release
  logic [CW-1:0] press_cnt_ff;
  logic held_ff;
  logic short_evt;
  logic force_evt;

  assign force_evt = sw_ff && !held_ff && press_cnt_ff == CW'(FORCE_OFF_CYC - 1);
  assign short_evt = sw_prev_ff && !sw_ff && !held_ff;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      press_cnt_ff <= '0;
    else if (!sw_ff)
      press_cnt_ff <= '0;
    else if (!held_ff)
      press_cnt_ff <= press_cnt_ff + 1'b1;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      held_ff <= 1'b0;
    else if (force_evt)
      held_ff <= 1'b1;
    else if (!sw_ff)
      held_ff <= 1'b0;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      press_over4_ff <= 1'b0;
    else
      press_over4_ff <= sw_ff && press_cnt_ff >= CW'(SHORT_PRESS_CYC);

  // ----------------------------------------
  // Power-state machine
  // ----------------------------------------
  logic init_done_ff;
  logic wake_hit;
  spsc_pkg::spsc_state_t nxt_state;

  assign wake_hit = wake_ok(state_ff, wake, cfg);

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      init_done_ff <= 1'b0;
    else
      init_done_ff <= 1'b1;

  always_comb
  begin
    nxt_state = state_ff;
    if (!init_done_ff)
    begin
      case (cfg.restore)
        spsc_pkg::RP_POWER_ON: nxt_state = spsc_pkg::ST_S0;
        spsc_pkg::RP_LAST: nxt_state = saved_last_on ? spsc_pkg::ST_S0 : spsc_pkg::ST_S5;
        default: nxt_state = spsc_pkg::ST_S5;
      endcase
    end
    else if (force_evt && state_ff != spsc_pkg::ST_S5)
      nxt_state = spsc_pkg::ST_S5;
    else
    begin
      case (state_ff)
        spsc_pkg::ST_S0:
          if (short_evt)
            nxt_state = spsc_pkg::ST_S3;
          else if (os_req)
            nxt_state = os_target;
        spsc_pkg::ST_S3, spsc_pkg::ST_S4, spsc_pkg::ST_S5:
          if (short_evt || wake_hit)
            nxt_state = spsc_pkg::ST_S0;
        default: nxt_state = spsc_pkg::ST_S5;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      state_ff <= spsc_pkg::ST_S5;
    else
      state_ff <= nxt_state;

  // ----------------------------------------
  // Supply, context and restore outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      psu_on_n_ff <= 1'b1;
      stby_on_ff <= 1'b1;
      ctx_ram_ff <= 1'b0;
      cold_boot_ff <= 1'b0;
      last_on_ff <= 1'b0;
    end
    else
    begin
      psu_on_n_ff <= nxt_state != spsc_pkg::ST_S0;
      stby_on_ff <= 1'b1;
      ctx_ram_ff <= nxt_state == spsc_pkg::ST_S3;
      cold_boot_ff <= nxt_state == spsc_pkg::ST_S0 &&
                      (state_ff == spsc_pkg::ST_S5 || !init_done_ff);
      last_on_ff <= nxt_state != spsc_pkg::ST_S5;
    end

  // ----------------------------------------
  // Fan gating and channels
  // ----------------------------------------
  logic [CW-1:0] pwm_div_ff;
  logic [CW-1:0] win_cnt_ff;
  logic pwm_tick_ff;
  logic win_tick_ff;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      fan_en_ff <= 1'b0;
    else
      fan_en_ff <= nxt_state == spsc_pkg::ST_S0;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      pwm_div_ff <= '0;
      pwm_tick_ff <= 1'b0;
    end
    else
    begin
      pwm_tick_ff <= pwm_div_ff == CW'(spsc_pkg::PWM_DIV_CYC - 1);
      pwm_div_ff <= (pwm_div_ff == CW'(spsc_pkg::PWM_DIV_CYC - 1)) ? '0 : pwm_div_ff + 1'b1;
    end

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      win_cnt_ff <= '0;
      win_tick_ff <= 1'b0;
    end
    else
    begin
      win_tick_ff <= win_cnt_ff == CW'(TACH_WIN_CYC - 1);
      win_cnt_ff <= (win_cnt_ff == CW'(TACH_WIN_CYC - 1)) ? '0 : win_cnt_ff + 1'b1;
    end

  genvar gi;
  generate
    for (gi = 0; gi < FAN_N; gi++)
    begin : g_fan
      spsc_fan_chan u_fan (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pwm_tick(pwm_tick_ff),
        .win_tick(win_tick_ff),
        .fan_en(fan_en_ff),
        .closed_loop(fan_closed_loop[gi]),
        .duty_set(fan_duty[gi]),
        .tach_target(fan_target[gi]),
        .tach_pin(fan_tach[gi]),
        .pwm_out_ff(fan_pwm[gi]),
        .tach_cnt_ff(fan_speed[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_short_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && !force_evt && short_evt && state_ff != spsc_pkg::ST_S0
    |=> state_ff == spsc_pkg::ST_S0 && !psu_on_n_ff)
    else $error("short press did not wake");

  chk_short_sleep: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && short_evt && state_ff == spsc_pkg::ST_S0
    |=> state_ff == spsc_pkg::ST_S3 && ctx_ram_ff)
    else $error("short press did not sleep");

  chk_force_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && sw_ff && !held_ff && press_cnt_ff == CW'(FORCE_OFF_CYC - 1)
    |=> state_ff == spsc_pkg::ST_S5 && held_ff)
    else $error("hold did not force soft-off");

  chk_no_release_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
    held_ff && sw_prev_ff && !sw_ff |=> $stable(state_ff))
    else $error("release after forced off changed state");

  chk_usb_s3_only: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && state_ff == spsc_pkg::ST_S5 && !short_evt &&
    wake == spsc_pkg::spsc_wake_t'(6'h08)
    |=> state_ff == spsc_pkg::ST_S5)
    else $error("usb woke from soft-off");

  chk_s4_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && state_ff == spsc_pkg::ST_S4 && !cfg.s4_os_ok && !short_evt
    |=> state_ff == spsc_pkg::ST_S4)
    else $error("wake from S4 without OS support");

  chk_pme_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && state_ff == spsc_pkg::ST_S5 && !short_evt && !cfg.pme_en &&
    wake == spsc_pkg::spsc_wake_t'(6'h04)
    |=> state_ff == spsc_pkg::ST_S5)
    else $error("disabled PME woke the system");

  chk_pcie_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && !force_evt && wake.pcie && state_ff != spsc_pkg::ST_S0 &&
    (state_ff != spsc_pkg::ST_S4 || cfg.s4_os_ok)
    |=> state_ff == spsc_pkg::ST_S0)
    else $error("WAKE did not wake");

  chk_cold_boot: assert property (@(posedge ref_clk) disable iff (!rstn)
    init_done_ff && $past(state_ff) == spsc_pkg::ST_S5 && state_ff == spsc_pkg::ST_S0
    |-> cold_boot_ff)
    else $error("leaving S5 not flagged cold boot");

  chk_os_directs: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_ff != $past(state_ff)
    |-> $past(os_req || short_evt || force_evt || wake_hit || !init_done_ff))
    else $error("state changed without cause");

  chk_rails_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_ff != spsc_pkg::ST_S0 |-> psu_on_n_ff && stby_on_ff)
    else $error("main rails on outside S0");

  chk_restore_last: assert property (@(posedge ref_clk) disable iff (!rstn)
    !init_done_ff && cfg.restore == spsc_pkg::RP_LAST
    |=> state_ff == (saved_last_on ? spsc_pkg::ST_S0 : spsc_pkg::ST_S5))
    else $error("last state not restored");

  chk_fan_on: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_ff == spsc_pkg::ST_S0 |-> fan_en_ff)
    else $error("fans off in S0");

  chk_fan_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_ff != spsc_pkg::ST_S0 |-> !fan_en_ff)
    else $error("fans on outside S0");

endmodule
`default_nettype wire

// ===== system_power_state_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module system_power_state_controller_tb;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  // Short counts keep the run brief; ordering DB < SP < FO is kept
  localparam int DB = 4;
  localparam int SP = 40;
  localparam int FO = 60;
  localparam int TW = 100;
  localparam int HALF [4] = '{5, 10, 25, 50};
  localparam spsc_pkg::spsc_state_t S0 = spsc_pkg::ST_S0;
  localparam spsc_pkg::spsc_state_t S3 = spsc_pkg::ST_S3;
  localparam spsc_pkg::spsc_state_t S4 = spsc_pkg::ST_S4;
  localparam spsc_pkg::spsc_state_t S5 = spsc_pkg::ST_S5;
  typedef struct {spsc_pkg::spsc_state_t tgt; int src; logic [2:0] c; logic wake;} spsc_row_t;
  // c is {pme_en, s4_os_ok, cir_deep_en}; src 0 rtc 1 lan 2 usb 3 pme 4 pcie 5 ir
  spsc_row_t rows [18] = '{'{S3, 0, 3'h0, 1'h1}, '{S3, 1, 3'h0, 1'h1}, '{S3, 2, 3'h0, 1'h1},
    '{S3, 3, 3'h0, 1'h0}, '{S3, 3, 3'h4, 1'h1}, '{S3, 4, 3'h0, 1'h1}, '{S3, 5, 3'h0, 1'h1},
    '{S4, 0, 3'h0, 1'h0}, '{S4, 0, 3'h2, 1'h1}, '{S4, 2, 3'h2, 1'h0}, '{S4, 5, 3'h2, 1'h0},
    '{S4, 5, 3'h3, 1'h1}, '{S5, 2, 3'h0, 1'h0}, '{S5, 1, 3'h0, 1'h1}, '{S5, 4, 3'h0, 1'h1},
    '{S5, 5, 3'h0, 1'h0}, '{S5, 3, 3'h4, 1'h1}, '{S5, 3, 3'h0, 1'h0}};
  // Restore cases {policy, saved bit}; RON marks those that power on
  localparam logic [2:0] RST [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
  localparam logic [5:0] RON = 6'h14;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic rtc_alarm = 1'h0, lan_wake = 1'h0, usb_wake = 1'h0, cir_wake = 1'h0;
  logic pme_n = 1'h1, pcie_wake_n = 1'h1, os_req = 1'h0, saved_last_on = 1'h0;
  spsc_pkg::spsc_state_t os_target = spsc_pkg::ST_S0;
  spsc_pkg::spsc_cfg_t cfg = '0;
  logic [3:0] fan_tach = 4'h0;
  logic [3:0][7:0] fan_duty = {8'hFF, 8'h80, 8'h40, 8'h00};
  logic [3:0] fan_loop = 4'h0;
  logic [3:0][15:0] fan_target = '0;
  logic psu_on_n_ff, stby_on_ff, ctx_ram_ff, cold_boot_ff, last_on_ff, press_over4_ff;
  logic fan_en_ff, pwr_sw_n, rail_main, rail_stby, cold_seen;
  spsc_pkg::spsc_state_t state_ff;
  logic [3:0] fan_pwm;
  logic [3:0][15:0] fan_speed;
  int n_errors = 0;
  int checks = 0;
  int tcnt = 0;

  always #12.5 ref_clk = !ref_clk;

  // Free-running tach pulses whose periods divide the window evenly
  always @(negedge ref_clk)
  begin
    tcnt <= tcnt + 1;
    for (int i = 0; i < 4; i++)
    begin
      if (tcnt % HALF[i] == 0) fan_tach[i] <= !fan_tach[i];
    end
  end

  spsc_top #(.DEBOUNCE_CYC(DB), .SHORT_PRESS_CYC(SP), .FORCE_OFF_CYC(FO), .TACH_WIN_CYC(TW)) dut
  (
    .ref_clk(ref_clk), .rstn(rstn), .pwr_sw_n(pwr_sw_n), .rtc_alarm(rtc_alarm),
    .lan_wake(lan_wake), .usb_wake(usb_wake), .pme_n(pme_n), .pcie_wake_n(pcie_wake_n),
    .cir_wake(cir_wake), .os_req(os_req), .os_target(os_target), .cfg(cfg),
    .saved_last_on(saved_last_on), .psu_on_n_ff(psu_on_n_ff), .stby_on_ff(stby_on_ff),
    .state_ff(state_ff), .ctx_ram_ff(ctx_ram_ff), .cold_boot_ff(cold_boot_ff),
    .last_on_ff(last_on_ff), .press_over4_ff(press_over4_ff), .fan_tach(fan_tach),
    .fan_closed_loop(fan_loop), .fan_duty(fan_duty), .fan_target(fan_target),
    .fan_en_ff(fan_en_ff),
    .fan_pwm(fan_pwm), .fan_speed(fan_speed)
  );

  spsc_panel_model panel
  (
    .ref_clk(ref_clk), .psu_on_n(psu_on_n_ff), .stby_on(stby_on_ff),
    .pwr_sw_n(pwr_sw_n), .rail_main(rail_main), .rail_stby(rail_stby)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_state(input string what, input spsc_pkg::spsc_state_t exp,
                           input spsc_pkg::spsc_state_t got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cmp_cnt(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Bounded wait; a run-out is a mismatch and ends the run
  task automatic wait_for(input spsc_pkg::spsc_state_t exp, input int bound);
    for (int i = 0; i < bound; i++)
    begin
      @(negedge ref_clk);
      if (state_ff === exp)
      begin
        cold_seen = cold_boot_ff;
        return;
      end
    end
    n_errors++;
    $display("MISMATCH wait state expected %0d seen %0d", exp, state_ff);
    summarize();
  endtask

  task automatic os_go(input spsc_pkg::spsc_state_t t);
    @(negedge ref_clk);
    os_target = t;
    os_req = 1'h1;
    @(negedge ref_clk);
    os_req = 1'h0;
  endtask

  task automatic press(input int n);
    panel.sw_set(1'h1);
    repeat (n) @(negedge ref_clk);
    panel.sw_set(1'h0);
  endtask

  task automatic set_wake(input int src, input logic act);
    case (src)
      0: rtc_alarm = act;
      1: lan_wake = act;
      2: usb_wake = act;
      3: pme_n = !act;
      4: pcie_wake_n = !act;
      default: cir_wake = act;
    endcase
  endtask

  // Counts over one whole PWM period, so the phase does not matter
  task automatic count_pwm(input logic [3:0][7:0] duty);
    int hi [4];
    hi = '{0, 0, 0, 0};
    repeat (spsc_pkg::PWM_DIV_CYC * spsc_pkg::PWM_STEPS)
    begin
      @(negedge ref_clk);
      for (int i = 0; i < 4; i++) hi[i] += (fan_pwm[i] === 1'h1);
    end
    for (int i = 0; i < 4; i++)
    begin
      cmp_cnt("pwm high", 16'(duty[i] * spsc_pkg::PWM_DIV_CYC), 16'(hi[i]));
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    cfg.restore = spsc_pkg::RP_POWER_ON;
    repeat (16) @(negedge ref_clk);
    rstn = 1'h1;
    wait_for(S0, 4);
    for (int r = 0; r < 18; r++)
    begin
      {cfg.pme_en, cfg.s4_os_ok, cfg.cir_deep_en} = rows[r].c;
      os_go(rows[r].tgt);
      cmp_state("os state", rows[r].tgt, state_ff);
      cmp_bit("psu_on_n", 1'h1, psu_on_n_ff);
      cmp_bit("rail_main", 1'h0, rail_main);
      cmp_bit("rail_stby", 1'h1, rail_stby);
      cmp_bit("fan_en off", 1'h0, fan_en_ff);
      cmp_bit("ctx_ram", rows[r].tgt == S3, ctx_ram_ff);
      cmp_bit("last_on", rows[r].tgt != S5, last_on_ff);
      set_wake(rows[r].src, 1'h1);
      if (rows[r].wake)
      begin
        wait_for(S0, 8);
        cmp_bit("cold_boot", rows[r].tgt == S5, cold_seen);
        cmp_bit("fan_en on", 1'h1, fan_en_ff);
      end
      else
      begin
        repeat (8) @(negedge ref_clk);
        cmp_state("refused wake", rows[r].tgt, state_ff);
      end
      set_wake(rows[r].src, 1'h0);
      repeat (4) @(negedge ref_clk);
      if (!rows[r].wake)
      begin
        press(20);
        wait_for(S0, 40);
      end
    end
    repeat (300) @(negedge ref_clk);
    for (int i = 0; i < 4; i++) cmp_cnt("fan_speed", 16'(TW / (2 * HALF[i])), fan_speed[i]);
    count_pwm(fan_duty);
    // Targets above, at and below the measured rate push each duty to a rail or hold it
    fan_target = {16'h0000, 16'h0002, 16'h0005, 16'hFFFF};
    fan_loop = 4'hF;
    repeat (260 * TW) @(negedge ref_clk);
    count_pwm({8'h00, 8'h80, 8'h40, 8'hFF});
    fan_loop = 4'h0;
    os_go(S3);
    repeat (20) @(negedge ref_clk);
    count_pwm('0);
    os_go(S5);
    cmp_state("os outside S0", S3, state_ff);
    press(20);
    wait_for(S0, 40);
    cmp_bit("cold_boot S3", 1'h0, cold_seen);
    press(20);
    wait_for(S3, 40);
    panel.sw_set(1'h1);
    repeat (70) @(negedge ref_clk);
    cmp_state("forced off from S3", S5, state_ff);
    panel.sw_set(1'h0);
    repeat (20) @(negedge ref_clk);
    cmp_state("release after force", S5, state_ff);
    press(20);
    wait_for(S0, 40);
    cmp_bit("cold_boot S5", 1'h1, cold_seen);
    panel.sw_set(1'h1);
    repeat (50) @(negedge ref_clk);
    cmp_bit("press_over4", 1'h1, press_over4_ff);
    panel.sw_set(1'h0);
    wait_for(S3, 20);
    press(20);
    wait_for(S0, 40);
    panel.sw_set(1'h1);
    repeat (70) @(negedge ref_clk);
    cmp_state("forced off from S0", S5, state_ff);
    cmp_bit("rail_main forced", 1'h0, rail_main);
    panel.sw_set(1'h0);
    repeat (20) @(negedge ref_clk);
    for (int k = 0; k < 6; k++)
    begin
      rstn = 1'h0;
      cfg.restore = spsc_pkg::spsc_restore_t'(RST[k][2:1]);
      saved_last_on = RST[k][0];
      repeat (16) @(negedge ref_clk);
      cmp_state("reset state", S5, state_ff);
      cmp_bit("reset fan_en", 1'h0, fan_en_ff);
      cmp_bit("reset stby", 1'h1, stby_on_ff);
      rstn = 1'h1;
      @(negedge ref_clk);
      cmp_state("restore", RON[k] ? S0 : S5, state_ff);
      cmp_bit("restore cold_boot", RON[k], cold_boot_ff);
      repeat (3) @(negedge ref_clk);
    end
    summarize();
  end
endmodule
`default_nettype wire
